// ---- rtl/dmtu_top.sv ----
/*
 * dual module timer unit: a slow module (aux a, core, aux b) and a
 * fast module (aux, core, capture/reload register), all 16 bits.
 * assumes: all pins synchronous to sys_clk_in; config held steady
 * by software; no register bus, every control is a port.
 */
`timescale 1ns/1ps
`include "dmtu_regs.svh"
module dmtu_top (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire dmtu_pkg::dmtu_cfg_t slow_cfg_in [3],
    input wire dmtu_pkg::dmtu_cfg_t fast_cfg_in [2],
    input wire logic fast_reload_en_in,
    input wire logic fast_clear_en_in,
    input wire logic [1:0] fast_cap_sel_in,
    input wire logic [1:0] fast_cap_edge_in,
    input wire dmtu_pkg::dmtu_wr_t wr_in,
    input wire logic slow_core_count_input_in,
    input wire logic slow_core_direction_input_in,
    input wire logic slow_aux_b_input_in,
    input wire logic fast_aux_input_in,
    input wire logic fast_aux_direction_in,
    input wire logic fast_core_input_in,
    input wire logic fast_capture_input_in,
    output logic [`DMTU_TW-1:0] slow_aux_a_out,
    output logic [`DMTU_TW-1:0] slow_core_out,
    output logic [`DMTU_TW-1:0] slow_aux_b_out,
    output logic [`DMTU_TW-1:0] fast_aux_out,
    output logic [`DMTU_TW-1:0] fast_core_out,
    output logic [`DMTU_TW-1:0] fast_fast_capture_reload_reg_out,
    output logic slow_toggle_output_out,
    output logic fast_toggle_output_out,
    output logic [2:0] slow_wrap_out,
    output logic [1:0] fast_wrap_out
);
    localparam int TW = `DMTU_TW;
    localparam int PSW = `DMTU_PSW;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // edge of a sampled level, per rising/falling select
    function automatic logic edge_hit(input logic p, input logic c,
                                      input logic [1:0] sel);
        edge_hit = (sel[0] & ~p & c) | (sel[1] & p & ~c);
    endfunction

    // prescaler tick: low lsb+presc bits of free counter all ones
    function automatic logic presc_hit(input logic [PSW-1:0] ps,
                                       input int lsb,
                                       input logic [2:0] p);
        logic [PSW-1:0] m;
        m = '0;
        for (int k = 0; k < PSW; k++) begin
            m[k] = (k < lsb + int'(p));
        end
        presc_hit = &(ps | ~m);
    endfunction

    // quadrature direction: A leads B counts up
    function automatic logic quad_dn(input logic a, input logic b,
                                     input logic a_edge);
        quad_dn = a_edge ? (a == b) : (a != b);
    endfunction

    // one step with wrap flag in the top bit
    function automatic logic [TW:0] step(input logic [TW-1:0] v,
                                         input logic dn);
        logic wrap;
        wrap = dn ? (v == '0) : (&v);
        step = {wrap, dn ? v - 1'b1 : v + 1'b1};
    endfunction

    // count pulse for the plain modes; roles give none
    function automatic logic cnt_pulse(input dmtu_pkg::dmtu_cfg_t c,
                                       input logic ptick,
                                       input logic pin,
                                       input logic pin_e,
                                       input logic tl_e,
                                       input logic aux);
        cnt_pulse = 1'b0;
        unique case (c.mode)
            dmtu_pkg::mode_timer: cnt_pulse = ptick;
            dmtu_pkg::mode_gated: cnt_pulse = ptick & (pin ^ c.gate_low);
            dmtu_pkg::mode_counter: begin
                cnt_pulse = (aux & c.src_tl) ? tl_e : pin_e;
            end
            dmtu_pkg::mode_encoder: cnt_pulse = 1'b0;
            dmtu_pkg::mode_capture: cnt_pulse = 1'b0;
            dmtu_pkg::mode_reload: cnt_pulse = 1'b0;
            default: cnt_pulse = 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // reset release and prescaler
    // ----------------------------------------
    logic [1:0] rst_sync_r; // bit0 seen only by bit1
    logic rst_n;
    logic [PSW-1:0] ps_r; // free running divider
    wire s_tick = &ps_r[`DMTU_SLOW_LSB-1:0];
    wire f_tick = &ps_r[`DMTU_FAST_LSB-1:0];

    // two flop release keeps every flop leaving reset together
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // divider shared by both modules, so ticks stay aligned
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ps_r <= '0;
        end else begin
            ps_r <= ps_r + 1'b1;
        end
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [TW-1:0] slow_r [3]; // aux a, core, aux b
    logic [TW-1:0] fast_r [2]; // aux, core
    logic [TW-1:0] fast_capture_reload_reg_r;   // fast capture/reload
    logic slow_tl_r, slow_tl_p_r, fast_tl_r, fast_tl_p_r;
    logic [2:0] s_pin_p_r, s_dir_p_r; // slow samples at base tick
    logic [1:0] f_pin_p_r, f_dir_p_r; // fast samples at base tick
    logic fast_capture_input_p_r;
    logic [2:0] s_wrap_r;
    logic [1:0] f_wrap_r;

    // unconnected pins are tied quiet here
    wire [2:0] s_pin = {slow_aux_b_input_in, slow_core_count_input_in,
                        1'b0};
    wire [2:0] s_dir = {1'b0, slow_core_direction_input_in, 1'b0};
    wire [1:0] f_pin = {fast_core_input_in, fast_aux_input_in};
    wire [1:0] f_dir = {1'b0, fast_aux_direction_in};

    // ----------------------------------------
    // slow module
    // ----------------------------------------
    wire [2:0] s_wrap, s_dn, s_cap, s_rld, s_wr;
    wire [TW:0] s_st [3];
    wire [2:0] s_pulse;
    wire s_tl_ev = slow_tl_r != slow_tl_p_r;

    for (genvar i = 0; i < 3; i++) begin : g_slow
        wire dmtu_pkg::dmtu_cfg_t c = slow_cfg_in[i];
        wire aux = (i != 1);
        wire ptick = s_tick & presc_hit(ps_r, `DMTU_SLOW_LSB, c.presc);
        wire a_e = s_tick & (s_pin_p_r[i] != s_pin[i]);
        wire b_e = s_tick & (s_dir_p_r[i] != s_dir[i]);
        wire pin_e = s_tick & edge_hit(s_pin_p_r[i], s_pin[i], c.edge_sel);
        wire tl_e = edge_hit(slow_tl_p_r, slow_tl_r, c.edge_sel);
        wire enc = c.mode == dmtu_pkg::mode_encoder;
        // encoder counts any selected A or B transition
        wire enc_p = (a_e & c.edge_sel[0]) | (b_e & c.edge_sel[1]);
        assign s_pulse[i] = enc ? enc_p
            : cnt_pulse(c, ptick, s_pin[i], pin_e, tl_e, aux);
        assign s_dn[i] = enc ? (quad_dn(s_pin[i], s_dir[i], a_e) ^ c.down)
            : (c.down ^ (c.ext_dir & s_dir[i]));
        assign s_st[i] = step(slow_r[i], s_dn[i]);
        assign s_wrap[i] = s_pulse[i] & s_st[i][TW];
        // role triggers only exist on the aux timers
        assign s_cap[i] = aux & (c.mode == dmtu_pkg::mode_capture) & pin_e;
        assign s_rld[i] = aux & (c.mode == dmtu_pkg::mode_reload)
            & (c.src_tl ? tl_e : pin_e);
        assign s_wr[i] = wr_in.en & (wr_in.sel == `DMTU_SEL_SLOW + 3'(i));
    end

    // aux a wins if both reload in one cycle; opposite edges never do
    wire core_rld = s_rld[0] | s_rld[2];
    wire [TW-1:0] rld_val = s_rld[0] ? slow_r[0] : slow_r[2];

    // software write first, then role action, then counting
    wire [TW-1:0] s_nxt [3];
    assign s_nxt[1] = s_wr[1] ? wr_in.data
        : core_rld ? rld_val
        : s_pulse[1] ? s_st[1][TW-1:0] : slow_r[1];
    for (genvar i = 0; i < 3; i += 2) begin : g_aux_nxt
        assign s_nxt[i] = s_wr[i] ? wr_in.data
            : s_cap[i] ? slow_r[1]
            : s_pulse[i] ? s_st[i][TW-1:0] : slow_r[i];
    end

    // slow timers, latch and samples
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            slow_r <= '{default: `DMTU_RST_VAL};
            slow_tl_r <= 1'b0;
            slow_tl_p_r <= 1'b0;
            s_pin_p_r <= 3'h0;
            s_dir_p_r <= 3'h0;
            s_wrap_r <= 3'h0;
        end else begin
            slow_r <= s_nxt;
            slow_tl_r <= slow_tl_r ^ s_wrap[1];
            slow_tl_p_r <= slow_tl_r;
            s_wrap_r <= s_wrap;
            if (s_tick) begin
                s_pin_p_r <= s_pin;
                s_dir_p_r <= s_dir;
            end
        end
    end

    // ----------------------------------------
    // fast module
    // ----------------------------------------
    wire [1:0] f_wrap, f_pulse, f_wr;
    wire [TW:0] f_st [2];

    for (genvar j = 0; j < 2; j++) begin : g_fast
        wire dmtu_pkg::dmtu_cfg_t c = fast_cfg_in[j];
        wire ptick = f_tick & presc_hit(ps_r, `DMTU_FAST_LSB, c.presc);
        wire pin_e = f_tick & edge_hit(f_pin_p_r[j], f_pin[j], c.edge_sel);
        wire tl_e = edge_hit(fast_tl_p_r, fast_tl_r, c.edge_sel);
        wire dn = c.down ^ (c.ext_dir & f_dir[j]);
        assign f_pulse[j] = cnt_pulse(c, ptick, f_pin[j], pin_e, tl_e,
                                      j == 0);
        assign f_st[j] = step(fast_r[j], dn);
        assign f_wrap[j] = f_pulse[j] & f_st[j][TW];
        assign f_wr[j] = wr_in.en & (wr_in.sel == `DMTU_SEL_FAST + 3'(j));
    end

    // capture trigger: pin, or slow core input transitions
    wire cap_pin = f_tick & edge_hit(fast_capture_input_p_r, fast_capture_input_in,
                                     fast_cap_edge_in);
    wire s_in_tr = s_tick & (s_pin_p_r[1] != s_pin[1]);
    wire s_dir_tr = s_tick & (s_dir_p_r[1] != s_dir[1]);
    wire cap_hit = (fast_cap_sel_in == 2'h0) ? cap_pin
        : ((fast_cap_sel_in[0] & s_in_tr) | (fast_cap_sel_in[1] & s_dir_tr));
    wire cap_wr = wr_in.en & (wr_in.sel == `DMTU_SEL_FAST_CAPTURE_RELOAD_REG);

    wire [TW-1:0] f_nxt [2];
    assign f_nxt[1] = f_wr[1] ? wr_in.data
        : (f_wrap[1] & fast_reload_en_in) ? fast_capture_reload_reg_r
        : f_pulse[1] ? f_st[1][TW-1:0] : fast_r[1];
    assign f_nxt[0] = f_wr[0] ? wr_in.data
        : (cap_hit & fast_clear_en_in) ? `DMTU_RST_VAL
        : f_pulse[0] ? f_st[0][TW-1:0] : fast_r[0];
    wire [TW-1:0] cap_nxt = cap_wr ? wr_in.data
        : cap_hit ? fast_r[0] : fast_capture_reload_reg_r;

    // fast timers, latch, capture register and samples
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fast_r <= '{default: `DMTU_RST_VAL};
            fast_capture_reload_reg_r <= `DMTU_RST_VAL;
            fast_tl_r <= 1'b0;
            fast_tl_p_r <= 1'b0;
            f_pin_p_r <= 2'h0;
            f_dir_p_r <= 2'h0;
            fast_capture_input_p_r <= 1'b0;
            f_wrap_r <= 2'h0;
        end else begin
            fast_r <= f_nxt;
            fast_capture_reload_reg_r <= cap_nxt;
            fast_tl_r <= fast_tl_r ^ f_wrap[1];
            fast_tl_p_r <= fast_tl_r;
            f_wrap_r <= f_wrap;
            if (f_tick) begin
                f_pin_p_r <= f_pin;
                f_dir_p_r <= f_dir;
                fast_capture_input_p_r <= fast_capture_input_in;
            end
        end
    end

    // ----------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------
    assign slow_aux_a_out = slow_r[0];
    assign slow_core_out = slow_r[1];
    assign slow_aux_b_out = slow_r[2];
    assign fast_aux_out = fast_r[0];
    assign fast_core_out = fast_r[1];
    assign fast_fast_capture_reload_reg_out = fast_capture_reload_reg_r;
    assign slow_toggle_output_out = slow_tl_r;
    assign fast_toggle_output_out = fast_tl_r;
    assign slow_wrap_out = s_wrap_r;
    assign fast_wrap_out = f_wrap_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n);

    sequence seq_slow_flip;
        slow_tl_r != $past(slow_tl_r);
    endsequence
    sequence seq_wrap_pulse;
        f_wrap_r[1] ##1 !f_wrap_r[1];
    endsequence

    AST_SLOW_TL:
        assert property (s_wrap[1] |=> seq_slow_flip)
        else $error("slow toggle latch missed a wrap");
    AST_SLOW_RES:
        assert property (!s_tick && !core_rld && !s_wr[1] |=> $stable(slow_r[1]))
        else $error("slow core moved off its tick");
    AST_AUX_STOP:
        assert property (slow_cfg_in[2].mode == dmtu_pkg::mode_reload && !s_wr[2]
                         |=> $stable(slow_r[2]))
        else $error("aux b counted while in reload role");
    AST_CAPTURE:
        assert property (s_cap[2] && !s_wr[2] |=> slow_r[2] == $past(slow_r[1]))
        else $error("aux b did not capture the core");
    AST_RELOAD:
        assert property (core_rld && !s_wr[1] |=> slow_r[1] == $past(rld_val))
        else $error("core did not take reload value");
    AST_NO_PIN:
        assert property (!s_cap[0] && !s_rld[0] || slow_cfg_in[0].src_tl)
        else $error("unconnected aux a pin produced an event");
    AST_FAST_RES:
        assert property (!f_tick && !f_wr[1] |=> $stable(fast_r[1]))
        else $error("fast core moved off its tick");
    AST_FAST_WRAP:
        assert property (f_wrap[1] |=> seq_wrap_pulse)
        else $error("fast wrap pulse wrong");
    AST_FAST_RLD:
        assert property (f_wrap[1] && fast_reload_en_in && !f_wr[1]
                         |=> fast_r[1] == $past(fast_capture_reload_reg_r))
        else $error("fast core not reloaded on wrap");
    AST_FAST_CAPTURE_RELOAD_REG:
        assert property (cap_hit && fast_clear_en_in && !f_wr[0] && !cap_wr
                         |=> fast_capture_reload_reg_r == $past(fast_r[0]) && fast_r[0] == '0)
        else $error("capture or clear of fast aux failed");
    AST_UP_WRAP:
        assert property (s_wrap[1] && !s_dn[1] && !core_rld && !s_wr[1]
                         |=> slow_r[1] == '0 && s_wrap_r[1])
        else $error("slow core up wrap wrong");
endmodule

// ---- rtl/dmtu_regs.svh ----
/*
 * constants of the dual module timer unit: widths, write selects,
 * reset values and tick divider positions.
 * assumes: included by its bare name, once or more.
 */
`ifndef DMTU_REGS_SVH
`define DMTU_REGS_SVH
// ----------------------------------------
// widths
// ----------------------------------------
`define DMTU_TW 16
`define DMTU_PSW 10
// ----------------------------------------
// tick positions: slow base every 4 clocks, fast every 2
// ----------------------------------------
`define DMTU_SLOW_LSB 2
`define DMTU_FAST_LSB 1
// ----------------------------------------
// software write selects
// ----------------------------------------
`define DMTU_SEL_SLOW 3'h0
`define DMTU_SEL_FAST 3'h3
`define DMTU_SEL_FAST_CAPTURE_RELOAD_REG 3'h5
// ----------------------------------------
// reset values
// ----------------------------------------
`define DMTU_RST_VAL 16'h0000
`endif

// ---- rtl/dmtu_pkg.sv ----
/*
 * types of the dual module timer unit: modes, per timer config,
 * software write bundle.
 * assumes: dmtu_regs.svh on the include path.
 */
`include "dmtu_regs.svh"
package dmtu_pkg;
    // ----------------------------------------
    // operating modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        mode_timer,
        mode_gated,
        mode_counter,
        mode_encoder,
        mode_capture,
        mode_reload
    } dmtu_mode_t;
    // ----------------------------------------
    // per timer configuration
    // ----------------------------------------
    typedef struct packed {
        dmtu_mode_t mode;     // operating mode
        logic [2:0] presc;    // extra divide by 2**presc
        logic down;           // software direction
        logic ext_dir;        // direction pin may flip it
        logic gate_low;       // gate active low
        logic [1:0] edge_sel; // bit0 rising, bit1 falling
        logic src_tl;         // aux: use toggle latch as source
    } dmtu_cfg_t;
    // ----------------------------------------
    // software write into a timer or capture reg
    // ----------------------------------------
    typedef struct packed {
        logic en;
        logic [2:0] sel;
        logic [`DMTU_TW-1:0] data;
    } dmtu_wr_t;
endpackage

// ---- testbench/dmtu_pin_model.sv ----
/*
 * pin side model of the dual module timer unit: gate, count,
 * direction, encoder and capture levels driven onto the timer pins.
 * assumes: one system clock; pins change 2 ns after a rising edge
 * and every level is held 8 clocks, slower than any base tick.
 */
`timescale 1ns/1ps
module dmtu_pin_model (
    input wire logic sys_clk_in,
    output logic [6:0] pins_out
);
    // ----------------------------------------
    // pin map
    // ----------------------------------------
    // 0 slow core count/gate/A, 1 slow core direction/B, 2 aux b,
    // 3 capture, 4 fast aux count, 5 fast aux dir, 6 fast core count
    initial pins_out = 7'h00;

    // wait n edges, then step off the edge
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk_in);
        #2;
    endtask

    // one level change, held long enough to be seen by a 4 clock tick
    task automatic set_pin(input int idx, input logic v);
        pins_out[idx] = v;
        hold(8);
    endtask

    // n full pulses on one pin
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            set_pin(idx, 1'b1);
            set_pin(idx, 1'b0);
        end
    endtask

    // quadrature steps on A (bit 0) and B (bit 1), one edge at a time
    task automatic quad(input int n, input logic fwd);
        repeat (n) begin
            if ((pins_out[0] == pins_out[1]) == fwd) begin
                set_pin(0, ~pins_out[0]);
            end else begin
                set_pin(1, ~pins_out[1]);
            end
        end
    endtask
endmodule

// ---- testbench/dmtu_top_test.sv ----
/*
 * self-checking bench of the dual module timer unit: config and
 * writes from the bench, pin events from the pin model.
 * assumes: dmtu_pkg compiled first; inputs move 2 ns after an edge.
 */
`timescale 1ns/1ps
`include "dmtu_regs.svh"
module dmtu_top_test;
    // ----------------------------------------
    // stimulus and observation
    // ----------------------------------------
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    dmtu_pkg::dmtu_cfg_t slow_cfg [3];
    dmtu_pkg::dmtu_cfg_t fast_cfg [2];
    logic reload_en = 1'b0;
    logic clear_en = 1'b0;
    logic [1:0] cap_sel = 2'h0;
    logic [1:0] cap_edge = 2'h1;
    dmtu_pkg::dmtu_wr_t wr = '0;
    logic [6:0] pins;
    logic [15:0] a_o, c_o, b_o, fa_o, fc_o, cr_o;
    logic stl, ftl;
    logic [2:0] sw;
    logic [1:0] fw;
    logic [15:0] v, va, vb, vf, d; // window start values
    logic l; // latch before a window
    int s; // wrap count before a window
    int w; // aux wrap count before a window
    int failures = 0;
    int checks = 0;
    int swraps = 0; // slow core wrap pulses seen
    int fwraps = 0; // fast core wrap pulses seen
    int awraps = 0; // aux timer wrap pulses seen

    always #12.5 sys_clk_in = ~sys_clk_in;

    // wrap pulses last one cycle, so count them at every edge
    always @(posedge sys_clk_in) begin
        if (sw[1] === 1'b1) swraps++;
        if (fw[1] === 1'b1) fwraps++;
        if (sw[0] === 1'b1 || sw[2] === 1'b1 || fw[0] === 1'b1) awraps++;
    end

    dmtu_pin_model pin_u (.sys_clk_in(sys_clk_in), .pins_out(pins));

    dmtu_top dut_u (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .slow_cfg_in(slow_cfg), .fast_cfg_in(fast_cfg),
        .fast_reload_en_in(reload_en), .fast_clear_en_in(clear_en),
        .fast_cap_sel_in(cap_sel), .fast_cap_edge_in(cap_edge), .wr_in(wr),
        .slow_core_count_input_in(pins[0]), .slow_core_direction_input_in(pins[1]),
        .slow_aux_b_input_in(pins[2]), .fast_capture_input_in(pins[3]),
        .fast_aux_input_in(pins[4]), .fast_aux_direction_in(pins[5]),
        .fast_core_input_in(pins[6]),
        .slow_aux_a_out(a_o), .slow_core_out(c_o), .slow_aux_b_out(b_o),
        .fast_aux_out(fa_o), .fast_core_out(fc_o), .fast_fast_capture_reload_reg_out(cr_o),
        .slow_toggle_output_out(stl), .fast_toggle_output_out(ftl),
        .slow_wrap_out(sw), .fast_wrap_out(fw)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #2;
    endtask

    // gate_low stays 0: every gate here is active high
    function automatic dmtu_pkg::dmtu_cfg_t mk(input dmtu_pkg::dmtu_mode_t m,
        input logic [2:0] p, input logic dn, input logic ed, input logic [1:0] es,
        input logic tl);
        mk = '{mode: m, presc: p, down: dn, ext_dir: ed, gate_low: 1'b0,
               edge_sel: es, src_tl: tl};
    endfunction

    // one-cycle software write, strobe dropped after the taking edge;
    // one idle edge after it, so back to back writes never re-raise
    // the strobe in the same time step that lowered it
    task automatic wr_reg(input logic [2:0] sel, input logic [15:0] dat);
        wr = '{en: 1'b1, sel: sel, data: dat};
        cyc(1);
        wr.en = 1'b0;
        cyc(1);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------
    // watchdog: the run needs about 1900 clocks
    // ----------------------------------------
    initial begin
        #250000;
        failures++;
        finish_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 3; i++) slow_cfg[i] = mk(dmtu_pkg::mode_timer, 3'h0, 1'b0, 1'b0, 2'h1, 1'b0);
        for (int i = 0; i < 2; i++) fast_cfg[i] = mk(dmtu_pkg::mode_timer, 3'h0, 1'b0, 1'b0, 2'h1, 1'b0);
        cyc(4);
        chk(c_o | a_o | b_o | fa_o | fc_o | cr_o, 16'h0000);
        cyc(1);
        rstn_in = 1'b1;
        cyc(3);
        // free running rates: 10 slow steps and 20 fast steps in 40 clocks
        v = c_o; va = a_o; vb = b_o; vf = fc_o; d = fa_o;
        cyc(40);
        chk(c_o - v, 16'h000A);
        chk(a_o - va, 16'h000A);
        chk(b_o - vb, 16'h000A);
        chk(fc_o - vf, 16'h0014);
        chk(fa_o - d, 16'h0014);
        // prescaler 2**2: one step per 16 clocks
        slow_cfg[1] = mk(dmtu_pkg::mode_timer, 3'h2, 1'b0, 1'b0, 2'h1, 1'b0);
        cyc(2);
        v = c_o;
        cyc(64);
        chk(c_o - v, 16'h0004);
        // counting down through zero: one underflow, latch flips
        slow_cfg[1] = mk(dmtu_pkg::mode_timer, 3'h0, 1'b1, 1'b0, 2'h1, 1'b0);
        // aux a counts up from near all ones: one up wrap in the window
        wr_reg(`DMTU_SEL_SLOW, 16'hFFFE);
        wr_reg(3'h1, 16'h0005);
        l = stl; s = swraps; v = c_o;
        w = awraps;
        cyc(40);
        chk(c_o, v - 16'h000A);
        chk(16'(swraps - s), 16'h0001);
        chk(16'(awraps - w), 16'h0001);
        chk({15'h0, stl}, {15'h0, ~l});
        // direction pin flips a software up count into down
        slow_cfg[1] = mk(dmtu_pkg::mode_timer, 3'h0, 1'b0, 1'b1, 2'h1, 1'b0);
        pin_u.set_pin(1, 1'b1);
        v = c_o;
        cyc(40);
        chk(v - c_o, 16'h000A);
        pin_u.set_pin(1, 1'b0);
        // gated: closed gate holds, open gate counts
        slow_cfg[1] = mk(dmtu_pkg::mode_gated, 3'h0, 1'b0, 1'b0, 2'h1, 1'b0);
        cyc(4);
        v = c_o;
        cyc(40);
        chk(c_o - v, 16'h0000);
        pin_u.set_pin(0, 1'b1);
        v = c_o;
        cyc(40);
        chk(c_o - v, 16'h000A);
        pin_u.set_pin(0, 1'b0);
        // counter on rising edges; aux a has no pin and must stay put
        slow_cfg[1] = mk(dmtu_pkg::mode_counter, 3'h0, 1'b0, 1'b0, 2'h1, 1'b0);
        slow_cfg[0] = mk(dmtu_pkg::mode_counter, 3'h0, 1'b0, 1'b0, 2'h3, 1'b0);
        wr_reg(`DMTU_SEL_SLOW, 16'h0055);
        v = c_o;
        pin_u.pulse(0, 5);
        chk(c_o - v, 16'h0005);
        chk(a_o, 16'h0055);
        // encoder: 8 quarter steps one way, then back to the start
        slow_cfg[1] = mk(dmtu_pkg::mode_encoder, 3'h0, 1'b0, 1'b0, 2'h3, 1'b0);
        cyc(4);
        v = c_o;
        pin_u.quad(8, 1'b1);
        d = c_o - v;
        chk(16'(d == 16'h0008 || d == 16'hFFF8), 16'h0001);
        pin_u.quad(8, 1'b0);
        chk(c_o, v);
        // aux b captures a stopped core, then stays stopped itself
        slow_cfg[1] = mk(dmtu_pkg::mode_counter, 3'h0, 1'b0, 1'b0, 2'h1, 1'b0);
        slow_cfg[2] = mk(dmtu_pkg::mode_capture, 3'h0, 1'b0, 1'b0, 2'h1, 1'b0);
        wr_reg(3'h1, 16'h1234);
        pin_u.pulse(2, 1);
        chk(b_o, 16'h1234);
        cyc(40);
        chk(b_o, 16'h1234);
        // alternate reloads on both latch edges: about 12 wraps in 1200
        slow_cfg[0] = mk(dmtu_pkg::mode_reload, 3'h0, 1'b0, 1'b0, 2'h1, 1'b1);
        slow_cfg[2] = mk(dmtu_pkg::mode_reload, 3'h0, 1'b0, 1'b0, 2'h2, 1'b1);
        slow_cfg[1] = mk(dmtu_pkg::mode_timer, 3'h0, 1'b0, 1'b0, 2'h1, 1'b0);
        wr_reg(`DMTU_SEL_SLOW, 16'hFFF0);
        wr_reg(3'h2, 16'hFFE0);
        wr_reg(3'h1, 16'hFFF0);
        s = swraps;
        cyc(1200);
        chk(16'(swraps - s inside {[11:14]}), 16'h0001);
        // fast aux counts fast latch edges; one fast wrap in 40 clocks
        fast_cfg[0] = mk(dmtu_pkg::mode_counter, 3'h0, 1'b0, 1'b0, 2'h3, 1'b1);
        wr_reg(`DMTU_SEL_FAST, 16'hFFFF);
        wr_reg(3'h4, 16'hFFF8);
        l = ftl; s = fwraps;
        w = awraps;
        cyc(40);
        chk(fa_o, 16'h0000);
        chk(16'(awraps - w), 16'h0001);
        chk({15'h0, ftl}, {15'h0, ~l});
        chk(16'(fwraps - s), 16'h0001);
        // capture pin rising edge takes fast aux and clears it
        fast_cfg[0] = mk(dmtu_pkg::mode_counter, 3'h0, 1'b0, 1'b0, 2'h1, 1'b0);
        clear_en = 1'b1;
        wr_reg(`DMTU_SEL_FAST, 16'h0ABC);
        pin_u.pulse(3, 1);
        chk(cr_o, 16'h0ABC);
        chk(fa_o, 16'h0000);
        // capture from slow core count input transitions, no clear
        cap_sel = 2'h1;
        clear_en = 1'b0;
        wr_reg(`DMTU_SEL_FAST, 16'h0DEF);
        pin_u.pulse(0, 1);
        chk(cr_o, 16'h0DEF);
        chk(fa_o, 16'h0DEF);
        // fast core reloads from the capture register on its wrap
        wr_reg(`DMTU_SEL_FAST_CAPTURE_RELOAD_REG, 16'hFFF0);
        reload_en = 1'b1;
        wr_reg(3'h4, 16'hFFFC);
        // 30 edges after the write: 15 steps, wrap at the 4th reloads FFF0
        cyc(29);
        chk(fc_o, 16'hFFFB);
        finish_test();
    end
endmodule
